/* core/bod_pkg.sv */
/*
  constants, field positions, opcode codes, register map and carrier types
  for the byte operation instruction decoder.
  assumes a single clock domain and a 32-bit axi4-lite register bus.
*/
package bod_pkg;

  // instruction word layout
  localparam int INSTR_W    = 14;
  localparam int FILE_AW    = 7;
  localparam int DATA_W     = 8;
  localparam int JUMP_W     = 11;
  localparam int DEST_BIT   = 7;
  localparam int OP_HI      = 11;
  localparam int OP_LO      = 8;
  localparam int BITSEL_HI  = 9;
  localparam int BITSEL_LO  = 7;
  localparam int CLS_HI     = 13;
  localparam int CLS_LO     = 12;
  localparam int SUBOP_HI   = 11;
  localparam int SUBOP_LO   = 10;

  // instruction classes in the two top bits
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_CTRL = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;

  // byte-oriented operation codes
  localparam logic [3:0] OP_MISC      = 4'h0;
  localparam logic [3:0] OP_CLEAR     = 4'h1;
  localparam logic [3:0] OP_SUBTRACT  = 4'h2;
  localparam logic [3:0] OP_DECREMENT = 4'h3;
  localparam logic [3:0] OP_OR        = 4'h4;
  localparam logic [3:0] OP_AND       = 4'h5;
  localparam logic [3:0] OP_XOR       = 4'h6;
  localparam logic [3:0] OP_ADD       = 4'h7;
  localparam logic [3:0] OP_MOVE      = 4'h8;
  localparam logic [3:0] OP_COMPL     = 4'h9;
  localparam logic [3:0] OP_INCREMENT = 4'ha;
  localparam logic [3:0] OP_DEC_SKIP  = 4'hb;
  localparam logic [3:0] OP_ROT_RIGHT = 4'hc;
  localparam logic [3:0] OP_ROT_LEFT  = 4'hd;
  localparam logic [3:0] OP_SWAP      = 4'he;
  localparam logic [3:0] OP_INC_SKIP  = 4'hf;

  // bit-oriented sub operations
  localparam logic [1:0] BOP_CLEAR     = 2'h0;
  localparam logic [1:0] BOP_SET       = 2'h1;
  localparam logic [1:0] BOP_SKIP_CLR  = 2'h2;

  localparam logic [INSTR_W-1:0] NOP_WORD   = 14'h0000;
  localparam logic [DATA_W-1:0]  ZERO_BYTE  = 8'h00;

  // register map, byte addresses
  localparam int ADDR_W_DEFAULT = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC    = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0c;
  localparam logic [7:0] REG_INSTR  = 8'h10;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_PRESC_BIT = 1;
  localparam int CTRL_W         = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // instruction cycle phases, gray coded, four clocks per cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } bod_phase_type;

  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [FILE_AW-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } bod_file_req_type;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } bod_flags_type;

endpackage : bod_pkg

/* core/bod_core.sv */
/*
  instruction decoder and sequencer for a small 8-bit accumulator core,
  with an axi4-lite slave for control and observation.
  assumes program memory answers imem_addr combinationally within a cycle,
  and file memory returns file_rdata on the clock after a read strobe.
*/
`timescale 1ns/10ps
`default_nettype none

module bod_core
  import bod_pkg::*;
#(
  parameter int                 PC_W           = 13,
  parameter int                 ADDR_W         = ADDR_W_DEFAULT,
  parameter logic [FILE_AW-1:0] PORT_FILE_ADDR = 7'h06,
  parameter logic [FILE_AW-1:0] TIMER_ZERO_ADDR = 7'h01
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [PC_W-1:0]        imem_addr,
  input  wire logic [INSTR_W-1:0] imem_data,
  output bod_file_req_type       file_req,
  input  wire logic [DATA_W-1:0] file_rdata,
  input  wire logic [DATA_W-1:0] port_pins,
  output logic                   prescaler_clear
);

  // sum with carry out and nibble carry, shared by add and subtract forms
  function automatic logic [DATA_W+1:0] add_dc(input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b,
                                               input logic              cin);
    logic [4:0]      lo;
    logic [DATA_W:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[DATA_W], lo[4], full[DATA_W-1:0]};
  endfunction : add_dc

  // does this word name a file register, so needs a read
  function automatic logic uses_file(input logic [INSTR_W-1:0] w);
    logic [3:0] op;
    op = w[OP_HI:OP_LO];
    if (w[CLS_HI:CLS_LO] == CLS_BIT) begin
      return 1'b1;
    end
    if (w[CLS_HI:CLS_LO] != CLS_BYTE) begin
      return 1'b0;
    end
    // clear-accumulator and no-operation carry no file address
    return !((op == OP_MISC || op == OP_CLEAR) && !w[DEST_BIT]);
  endfunction : uses_file

  bod_phase_type     phase, next_phase;
  logic [INSTR_W-1:0] instr, next_instr;
  logic [PC_W-1:0]   pc, next_pc;
  logic [DATA_W-1:0] acc, next_acc;
  bod_flags_type     flags, next_flags;
  logic              flush, next_flush;
  bod_file_req_type  next_file_req;
  logic              next_prescaler_clear;
  logic [CTRL_W-1:0] ctrl, next_ctrl;

  assign imem_addr = pc;

  // core sequencing: fetch in q1, read in q2, execute and commit in q3
  always_comb begin
    logic [DATA_W-1:0]   src;
    logic [DATA_W-1:0]   res;
    logic [DATA_W+1:0]   sum;
    logic [DATA_W-1:0]   mask;
    logic [DATA_W-1:0]   lit;
    logic [3:0]          op;
    logic                dest;
    logic                wr_f;
    logic                wr_w;
    logic                skip;
    logic                jump;
    bod_flags_type       fl;
    src  = ZERO_BYTE;
    res  = ZERO_BYTE;
    sum  = '0;
    mask = ZERO_BYTE;
    lit  = instr[DATA_W-1:0];
    op   = instr[OP_HI:OP_LO];
    dest = instr[DEST_BIT];
    wr_f = 1'b0;
    wr_w = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    fl   = flags;
    next_phase           = phase;
    next_instr           = instr;
    next_pc              = pc;
    next_acc             = acc;
    next_flags           = flags;
    next_flush           = flush;
    next_file_req        = '0;
    next_prescaler_clear = 1'b0;
    unique case (phase)
      PH_Q1: begin
        // halting between cycles only, so a stopped core never splits one
        if (ctrl[CTRL_RUN_BIT]) begin
          next_phase = PH_Q2;
          // the word fetched behind a skip or jump is dropped as a nop
          next_instr = flush ? NOP_WORD : imem_data;
          next_flush = 1'b0;
          next_file_req.rd   = uses_file(next_instr);
          next_file_req.addr = next_instr[FILE_AW-1:0];
        end
      end
      PH_Q2: begin
        next_phase = PH_Q3;
      end
      PH_Q3: begin
        next_phase = PH_Q4;
        // port reads see the pins so modify-in-place reflects real levels
        src = (instr[FILE_AW-1:0] == PORT_FILE_ADDR) ? port_pins : file_rdata;
        unique case (instr[CLS_HI:CLS_LO])
          CLS_BYTE: begin
            wr_f = dest;
            wr_w = !dest;
            unique case (op)
              OP_ADD: begin
                sum = add_dc(src, acc, 1'b0);
                res = sum[DATA_W-1:0];
                fl  = '{sum[DATA_W+1], sum[DATA_W], res == ZERO_BYTE};
              end
              OP_SUBTRACT: begin
                // carry reads as not-borrow
                sum = add_dc(src, ~acc, 1'b1);
                res = sum[DATA_W-1:0];
                fl  = '{sum[DATA_W+1], sum[DATA_W], res == ZERO_BYTE};
              end
              OP_AND:       res = src & acc;
              OP_OR:        res = src | acc;
              OP_XOR:       res = src ^ acc;
              OP_COMPL:     res = ~src;
              OP_MOVE:      res = src;
              OP_DECREMENT: res = src - 8'h01;
              OP_INCREMENT: res = src + 8'h01;
              OP_DEC_SKIP: begin
                res  = src - 8'h01;
                skip = (res == ZERO_BYTE);
              end
              OP_INC_SKIP: begin
                res  = src + 8'h01;
                skip = (res == ZERO_BYTE);
              end
              OP_ROT_LEFT: begin
                res      = {src[DATA_W-2:0], flags.carry};
                fl.carry = src[DATA_W-1];
              end
              OP_ROT_RIGHT: begin
                res      = {flags.carry, src[DATA_W-1:1]};
                fl.carry = src[0];
              end
              OP_SWAP:      res = {src[3:0], src[DATA_W-1:4]};
              OP_CLEAR: begin
                res     = ZERO_BYTE;
                fl.zero = 1'b1;
              end
              OP_MISC: begin
                // low bits are don't-care when the store bit is clear
                res  = acc;
                wr_w = 1'b0;
              end
            endcase
            if (op inside {OP_AND, OP_OR, OP_XOR, OP_COMPL, OP_MOVE,
                           OP_DECREMENT, OP_INCREMENT}) begin
              fl.zero = (res == ZERO_BYTE);
            end
          end
          CLS_BIT: begin
            mask = 8'h01 << instr[BITSEL_HI:BITSEL_LO];
            unique case (instr[SUBOP_HI:SUBOP_LO])
              BOP_CLEAR: begin
                res  = src & ~mask;
                wr_f = 1'b1;
              end
              BOP_SET: begin
                res  = src | mask;
                wr_f = 1'b1;
              end
              BOP_SKIP_CLR: skip = ((src & mask) == ZERO_BYTE);
              default:      skip = ((src & mask) != ZERO_BYTE);
            endcase
          end
          CLS_CTRL: begin
            // only the jump form is sequenced; the call form has no stack here
            jump = instr[SUBOP_HI];
          end
          default: begin
            wr_w = 1'b1;
            casez (instr[OP_HI:OP_LO])
              4'b00??: res = lit;
              4'b1000: res = lit | acc;
              4'b1001: res = lit & acc;
              4'b1010: res = lit ^ acc;
              4'b110?: sum = add_dc(lit, ~acc, 1'b1);
              4'b111?: sum = add_dc(lit, acc, 1'b0);
              default: wr_w = 1'b0;
            endcase
            if (instr[OP_HI:OP_LO+2] == 2'b11) begin
              res = sum[DATA_W-1:0];
              fl  = '{sum[DATA_W+1], sum[DATA_W], res == ZERO_BYTE};
            end else if (instr[OP_HI]) begin
              fl.zero = (res == ZERO_BYTE);
            end
          end
        endcase
        if (wr_w) begin
          next_acc = res;
        end
        next_flags            = fl;
        next_file_req.wr      = wr_f;
        next_file_req.addr    = instr[FILE_AW-1:0];
        next_file_req.wdata   = res;
        next_prescaler_clear  = wr_f && (instr[FILE_AW-1:0] == TIMER_ZERO_ADDR)
                                && ctrl[CTRL_PRESC_BIT];
        // the flushed second cycle still steps the counter, so aim one short of the target
        next_pc    = jump ? {pc[PC_W-1:JUMP_W], instr[JUMP_W-1:0]} - PC_W'(1)
                          : pc + PC_W'(1);
        next_flush = skip || jump;
      end
      PH_Q4: begin
        next_phase = PH_Q1;
      end
    endcase
  end

  // core state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase           <= PH_Q1;
      instr           <= NOP_WORD;
      pc              <= '0;
      acc             <= ZERO_BYTE;
      flags           <= '0;
      flush           <= 1'b0;
      file_req        <= '0;
      prescaler_clear <= 1'b0;
    end else begin
      phase           <= next_phase;
      instr           <= next_instr;
      pc              <= next_pc;
      acc             <= next_acc;
      flags           <= next_flags;
      flush           <= next_flush;
      file_req        <= next_file_req;
      prescaler_clear <= next_prescaler_clear;
    end
  end

  logic              aw_have, next_aw_have;
  logic              w_have, next_w_have;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0]        w_byte, next_w_byte;
  logic              w_lane, next_w_lane;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;

  // address and data may arrive in either order; hold each until both
  assign awready = !aw_have && !bvalid;
  assign wready  = !w_have && !bvalid;
  assign arready = !rvalid;

  // register bus slave
  always_comb begin
    logic [7:0] ra;
    logic [7:0] wa;
    ra = 8'(araddr) & 8'hfc;
    wa = 8'(aw_addr) & 8'hfc;
    next_aw_have = aw_have;
    next_w_have  = w_have;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bresp   = bresp;
    next_bvalid  = bvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_rvalid  = rvalid;
    next_ctrl    = ctrl;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    if (aw_have && w_have) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wa == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      if (wa == REG_CTRL && w_lane) begin
        next_ctrl = w_byte[CTRL_W-1:0];
      end
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (ra)
        REG_CTRL:   next_rdata = 32'(ctrl);
        REG_STATUS: next_rdata = 32'({phase, flush, flags});
        REG_ACC:    next_rdata = 32'(acc);
        REG_PC:     next_rdata = 32'(pc);
        REG_INSTR:  next_rdata = 32'(instr);
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  // bus state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      bresp   <= RESP_OKAY;
      bvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      ctrl    <= CTRL_RESET;
    end else begin
      aw_have <= next_aw_have;
      w_have  <= next_w_have;
      aw_addr <= next_aw_addr;
      w_byte  <= next_w_byte;
      w_lane  <= next_w_lane;
      bresp   <= next_bresp;
      bvalid  <= next_bvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      rvalid  <= next_rvalid;
      ctrl    <= next_ctrl;
    end
  end

endmodule : bod_core

`default_nettype wire

/* dv/bod_mem_model.sv */
/*
  program memory and file space model for the byte operation decoder.
  assumes the decoder fetches combinationally and reads file data the cycle after rd.
*/
`timescale 1ns/10ps
`default_nettype none
module bod_mem_model
  import bod_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic [12:0]       imem_addr,
  output logic [INSTR_W-1:0]     imem_data,
  input  wire bod_file_req_type  file_req,
  output logic [DATA_W-1:0]      file_rdata
);
  logic [INSTR_W-1:0] prog [256];
  logic [DATA_W-1:0]  fmem [128]; // whole 7-bit file space
  logic [DATA_W-1:0]  rd_q;
  logic               rd_v;
  // whole 14-bit words answer at once
  assign imem_data = prog[imem_addr[7:0]];
  // data only valid the cycle after rd; inverted otherwise so stale use shows
  assign file_rdata = rd_v ? rd_q : ~rd_q;
  // plain always so the bench may preload fmem
  always @(posedge aclk) begin
    rd_v <= file_req.rd;
    if (file_req.rd) rd_q <= fmem[file_req.addr];
    if (file_req.wr) fmem[file_req.addr] <= file_req.wdata;
  end
endmodule : bod_mem_model
`default_nettype wire

/* dv/bod_core_monitor.sv */
/*
  concurrent checks on the bod_core ports.
  assumes it is bound onto bod_core, single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module bod_core_monitor
  import bod_pkg::*;
#(
  parameter int                 PC_W            = 13,
  parameter logic [FILE_AW-1:0] TIMER_ZERO_ADDR = 7'h01
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             awvalid,
  input wire logic             awready,
  input wire logic             wvalid,
  input wire logic             wready,
  input wire logic [1:0]       bresp,
  input wire logic             bvalid,
  input wire logic             bready,
  input wire logic             arvalid,
  input wire logic             arready,
  input wire logic [31:0]      rdata,
  input wire logic             rvalid,
  input wire logic             rready,
  input wire logic [PC_W-1:0]  imem_addr,
  input wire bod_file_req_type file_req,
  input wire logic             prescaler_clear
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until the master takes them
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  b_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken while response pending");
  // one file read per four-clock instruction cycle
  rd_spacing_a: assert property (file_req.rd |=> !file_req.rd [*3])
    else $error("file reads closer than one instruction cycle");
  pc_step_a: assert property ($changed(imem_addr) |=> $stable(imem_addr) [*3])
    else $error("program counter moved within an instruction cycle");
  rmw_order_a: assert property (file_req.wr |-> $past(file_req.rd, 2)
    && file_req.addr == $past(file_req.addr, 2))
    else $error("file write without prior read of same address");
  presc_target_a: assert property (prescaler_clear |-> file_req.wr
    && file_req.addr == TIMER_ZERO_ADDR)
    else $error("prescaler clear without timer count write");
endmodule : bod_core_monitor
`default_nettype wire

/* dv/byte_op_instruction_decoder_bench.sv */
/*
  self-checking bench: runs short programs from the model and checks results
  over axi4-lite and in the model file space. assumes bod_core with default parameters and bod_mem_model.
*/
`timescale 1ns/10ps
`default_nettype none
module byte_op_instruction_decoder_bench;
  import bod_pkg::*;
  logic             aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]      wdata = 32'h0000_0000;
  logic [3:0]       wstrb = 4'h0;
  logic             awready, wready, bvalid, arready, rvalid, prescaler_clear;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  logic [12:0]      imem_addr;
  logic [13:0]      imem_data;
  bod_file_req_type file_req;
  logic [7:0]       file_rdata;
  logic [7:0]       port_pins = 8'ha5;
  int               fail_count = 0, samples_checked = 0, cyc = 0, presc_cnt = 0;
  logic [31:0]      d;
  logic [1:0]       r;

  bod_core dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .imem_addr(imem_addr), .imem_data(imem_data), .file_req(file_req),
    .file_rdata(file_rdata), .port_pins(port_pins), .prescaler_clear(prescaler_clear));
  bod_mem_model mem_u (.aclk(aclk), .imem_addr(imem_addr), .imem_data(imem_data),
    .file_req(file_req), .file_rdata(file_rdata));

  initial begin
    forever #20 aclk = ~aclk;
  end
  // count prescaler clears per run; a hang ends the run as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!aresetn) presc_cnt <= 0;
    else if (prescaler_clear) presc_cnt <= presc_cnt + 1;
    if (cyc == 10000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  // each channel released at its own handshake; response held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  // reset, load program padded with its closing jump, run, halt
  task automatic run_prog(input logic [13:0] p [$], input logic [31:0] ctl);
    logic [1:0] rs;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    for (int i = 0; i < 8; i++)
      mem_u.prog[i] = (i < p.size()) ? p[i] : 14'h2800 | 14'(p.size() - 1);
    aresetn <= 1'b1;
    axi_wr(REG_CTRL, ctl, rs);
    repeat (60) @(posedge aclk);
    axi_wr(REG_CTRL, 32'h0000_0000, rs);
    repeat (8) @(posedge aclk);
  endtask : run_prog
  task automatic chk_core(input logic [31:0] acc, input logic [31:0] flg);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_rd(REG_ACC, v, rs);
    chk("acc", acc, v);
    axi_rd(REG_STATUS, v, rs);
    chk("flags", flg, v & 32'h0000_0007);
  endtask : chk_core
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  initial begin
    mem_u.fmem[7'h06] = 8'h00; mem_u.fmem[7'h20] = 8'hf1; mem_u.fmem[7'h21] = 8'h01;
    mem_u.fmem[7'h22] = 8'h81; mem_u.fmem[7'h23] = 8'h01; mem_u.fmem[7'h24] = 8'h5a;
    // add literal 0f to f1 in file, result to file: carry, digit carry, zero
    run_prog('{14'h300f, 14'h07a0, 14'h2802}, 32'h0000_0001);
    chk_core(32'h0000_000f, 32'h0000_0007);
    chk("file20", 8'h00, mem_u.fmem[7'h20]);
    // decrement to zero into acc skips the literal load, no flags
    run_prog('{14'h0b21, 14'h3055, 14'h2802}, 32'h0000_0001);
    chk_core(32'h0000_0000, 32'h0000_0000);
    chk("file21", 8'h01, mem_u.fmem[7'h21]);
    // rotate left to file, then right into acc through the carry
    run_prog('{14'h0da2, 14'h0c23, 14'h2802}, 32'h0000_0001);
    chk_core(32'h0000_0080, 32'h0000_0004);
    chk("file22", 8'h02, mem_u.fmem[7'h22]);
    // store acc, clear file, and, nop with don't-care bits, clear acc with don't-cares
    run_prog('{14'h303c, 14'h00a5, 14'h01a4, 14'h0525, 14'h0060, 14'h017f}, 32'h0000_0001);
    chk_core(32'h0000_0000, 32'h0000_0001);
    chk("file25", 8'h3c, mem_u.fmem[7'h25]);
    chk("file24", 8'h00, mem_u.fmem[7'h24]);
    // bit set, bit test skips a load, goto lands on the load that must run
    mem_u.fmem[7'h27] = 8'h40;
    run_prog('{14'h15a7, 14'h1da7, 14'h3055, 14'h2805, 14'h3099, 14'h3011, 14'h2806},
             32'h0000_0001);
    chk_core(32'h0000_0011, 32'h0000_0000);
    chk("file27", 8'h48, mem_u.fmem[7'h27]);
    // increment skip, or with port pins, store to timer count, prescaler off then on
    for (int k = 1; k < 4; k += 2) begin
      mem_u.fmem[7'h26] = 8'hff;
      mem_u.fmem[7'h01] = 8'h00;
      run_prog('{14'h0fa6, 14'h3077, 14'h0406, 14'h0081, 14'h2804}, 32'(k));
      chk_core(32'h0000_00a5, 32'h0000_0000);
      chk("file26", 8'h00, mem_u.fmem[7'h26]);
      chk("presc", 32'(k == 3), 32'(presc_cnt));
    end
    // register bus: readback, read-only write, unmapped read
    axi_wr(REG_CTRL, 32'h0000_0002, r);
    axi_rd(REG_CTRL, d, r);
    chk("ctrl", 32'h0000_0002, d);
    axi_wr(REG_STATUS, 32'h0000_0007, r);
    chk("status_wr_resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, r});
    axi_rd(8'h14, d, r);
    chk("unmapped_resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, r});
    chk("unmapped_data", 32'h0000_0000, d);
    final_report();
  end
endmodule : byte_op_instruction_decoder_bench

bind bod_core bod_core_monitor #(.PC_W(PC_W), .TIMER_ZERO_ADDR(TIMER_ZERO_ADDR)) mon_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .imem_addr(imem_addr), .file_req(file_req), .prescaler_clear(prescaler_clear));
`default_nettype wire
